// ==== logic/mcs_cmd_bank.sv ====
// Manufacturer command bank: option registers, trim readback and status history recorder
`timescale 1ns/100ps
module mcs_cmd_bank
  import mcs_pkg::*;
#(
  parameter logic [TIMER_W-1:0] INTERVAL_CYC = TIMER_W'(HIST_INTERVAL_CYC)
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire mcs_cmd_type cmd,
  input wire logic ramp_done,
  input wire logic [15:0] status_word,
  input wire logic [15:0] vin_offset_on,
  input wire logic [15:0] vin_offset_off,
  input wire logic [15:0] vout_trim,
  input wire logic vin_below_thr,
  output mcs_resp_type resp,
  output mcs_ctl_type ctl,
  output logic rec_busy,
  output logic rec_full
);

  mcs_state_type st_q;
  mcs_state_type st_d;
  logic [7:0] opt_next;
  logic wr_allowed;

  // Next state of the whole block
  always_comb
  begin
    st_d = st_q;
    opt_next = st_q.special_opt;
    wr_allowed = 1'b0;
    st_d.resp.valid = 1'b0;

    // Recorder: starts at ramp end, one sample per interval, stops at sixteen
    case (st_q.rec)
      REC_WAIT:
      begin
        if (ramp_done)
        begin
          st_d.rec = REC_RUN; // [RL5]
          st_d.timer = '0;
          st_d.count = '0;
        end
      end
      REC_RUN:
      begin
        if (st_q.timer == INTERVAL_CYC - TIMER_W'(1))
        begin
          st_d.timer = '0;
          st_d.hist[st_q.count[3:0]] = status_word; // [RL5]
          st_d.count = st_q.count + 5'h01;
          if (st_q.count + 5'h01 == HIST_LAST)
          begin
            st_d.rec = REC_DONE; // [RL5]
          end
        end
        else
        begin
          st_d.timer = st_q.timer + TIMER_W'(1);
        end
      end
      REC_DONE:
      begin
        // Only the first start-up after reset is kept; a later ramp is not recorded
        st_d.rec = REC_DONE;
      end
      default:
      begin
        st_d.rec = REC_WAIT;
      end
    endcase

    // Command decode; answered one cycle after the request
    if (cmd.valid)
    begin
      st_d.resp.valid = 1'b1;
      st_d.resp.ack = 1'b0;
      st_d.resp.len = '0;
      st_d.resp.data = '0;
      // A write lacking PEC while PEC is required is refused and changes nothing
      wr_allowed = cmd.write && (cmd.pec_ok || !st_q.special_opt[OPT_PEC_BIT]); // [RL7]
      case (cmd.code)
        CMD_TEMP_SRC:
        begin
          st_d.resp.len = LEN_BYTE;
          if (cmd.write)
          begin
            st_d.resp.ack = wr_allowed;
            if (wr_allowed)
            begin
              st_d.temp_src = {7'h00, cmd.data[TEMP_SRC_BIT]}; // [RL1]
            end
          end
          else
          begin
            st_d.resp.ack = 1'b1;
            st_d.resp.data = {248'h0, st_q.temp_src};
          end
        end
        CMD_VIN_OFFSET:
        begin
          // Read-only: a write is nacked
          st_d.resp.ack = !cmd.write;
          st_d.resp.len = LEN_BLK4;
          st_d.resp.data = {224'h0, vin_offset_on, vin_offset_off}; // [RL2]
        end
        CMD_VOUT_TRIM:
        begin
          st_d.resp.ack = !cmd.write;
          st_d.resp.len = LEN_WORD;
          st_d.resp.data = {240'h0, vout_trim}; // [RL3]
        end
        CMD_STATUS_HIST:
        begin
          st_d.resp.ack = !cmd.write;
          st_d.resp.len = LEN_BLK32;
          st_d.resp.data = st_q.hist; // [RL4]
        end
        CMD_SPECIAL_OPT:
        begin
          st_d.resp.len = LEN_BYTE;
          if (cmd.write)
          begin
            st_d.resp.ack = wr_allowed;
            if (wr_allowed)
            begin
              opt_next = cmd.data & OPT_WR_MASK; // [RL6] [RL12]
            end
          end
          else
          begin
            st_d.resp.ack = 1'b1;
            st_d.resp.data = {248'h0, st_q.special_opt};
          end
        end
        default:
        begin
          // Unsupported command: nack, zero length
          st_d.resp.ack = 1'b0;
        end
      endcase
    end
    st_d.special_opt = opt_next;

    // Controls follow the stored values; a new PEC setting applies from the next command
    st_d.ctl.temp_external = st_d.temp_src[TEMP_SRC_BIT]; // [RL1]
    st_d.ctl.pec_required = st_d.special_opt[OPT_PEC_BIT]; // [RL7]
    st_d.ctl.hrr_enable = st_d.special_opt[OPT_HRR_BIT]; // [RL8]
    st_d.ctl.ratio_track = st_d.special_opt[OPT_HRR_BIT] && vin_below_thr; // [RL8]
    st_d.ctl.droop_nonlinear = st_d.special_opt[OPT_DLS_BIT]; // [RL9]
    st_d.ctl.adaptive_ramp_loop_comp_enable = st_d.special_opt[OPT_ART_BIT]; // [RL10]
    st_d.ctl.dbv_enable = st_d.special_opt[OPT_DBV_BIT]; // [RL11]
  end

  // State register, frozen while ce is low unless rst_b is low
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.temp_src <= TEMP_SRC_RST;
      st_q.special_opt <= SPECIAL_OPT_RST;
      st_q.rec <= REC_WAIT;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign resp = st_q.resp;
  assign ctl = st_q.ctl;
  assign rec_busy = (st_q.rec == REC_RUN);
  assign rec_full = (st_q.rec == REC_DONE);

endmodule : mcs_cmd_bank

// ==== logic/mcs_pkg.sv ====
// Package: command codes, field layout, timing and carrier types for the mfr command bank
// Notes on behaviour
// RL1: 0xDC bit0: 0 internal, 1 remote sensor
// RL2: 0xDD returns on-offset high, off-offset low
// RL3: 0xDE returns signed output trim word
// RL4: 0xDF returns sixteen words, word15 on top
// RL5: Record each 8 s after ramp, sixteen words
// RL6: 0xE0 bits 0 and 1 reserved
// RL7: Bit7 set means writes need PEC byte
// RL8: Bit6 enables ratio tracking below threshold
// RL9: Bit5 picks linear or non-linear droop
// RL10: Bit3 enables adaptive ramp and loop comp
// RL11: Bit2 enables dynamic bus voltage
// RL12: Reserved bits and bit4 ignored, read zero
package mcs_pkg;

  // Command codes
  localparam logic [7:0] CMD_TEMP_SRC = 8'hDC;
  localparam logic [7:0] CMD_VIN_OFFSET = 8'hDD;
  localparam logic [7:0] CMD_VOUT_TRIM = 8'hDE;
  localparam logic [7:0] CMD_STATUS_HIST = 8'hDF;
  localparam logic [7:0] CMD_SPECIAL_OPT = 8'hE0;

  // Answer lengths in bytes
  localparam logic [5:0] LEN_BYTE = 6'h01;
  localparam logic [5:0] LEN_WORD = 6'h02;
  localparam logic [5:0] LEN_BLK4 = 6'h04;
  localparam logic [5:0] LEN_BLK32 = 6'h20;

  // Field positions
  localparam int TEMP_SRC_BIT = 0;
  localparam int OPT_DBV_BIT = 2;
  localparam int OPT_ART_BIT = 3;
  localparam int OPT_DLS_BIT = 5;
  localparam int OPT_HRR_BIT = 6;
  localparam int OPT_PEC_BIT = 7;
  localparam logic [7:0] OPT_WR_MASK = 8'hEC;

  // Reset values
  localparam logic [7:0] TEMP_SRC_RST = 8'h00;
  localparam logic [7:0] SPECIAL_OPT_RST = 8'h00;

  // History geometry and timing
  localparam int HIST_WORDS = 16;
  localparam logic [4:0] HIST_LAST = 5'h10;
  localparam int TIMER_W = 32;
  localparam int CLK_HZ = 100000000;
  localparam int HIST_INTERVAL_S = 8;
  localparam longint HIST_INTERVAL_CYC = longint'(HIST_INTERVAL_S) * longint'(CLK_HZ);

  // Recorder states, Gray along the path
  typedef enum logic [1:0] {
    REC_WAIT = 2'b00,
    REC_RUN = 2'b01,
    REC_DONE = 2'b11
  } mcs_rec_type;

  // Command from the PMBus engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] data;
    logic pec_ok;
  } mcs_cmd_type;

  // Answer to the PMBus engine
  typedef struct packed {
    logic valid;
    logic ack;
    logic [5:0] len;
    logic [255:0] data;
  } mcs_resp_type;

  // Option controls to the power stage
  typedef struct packed {
    logic temp_external;
    logic pec_required;
    logic hrr_enable;
    logic ratio_track;
    logic droop_nonlinear;
    logic adaptive_ramp_loop_comp_enable;
    logic dbv_enable;
  } mcs_ctl_type;

  // Whole block state
  typedef struct packed {
    logic [7:0] temp_src;
    logic [7:0] special_opt;
    mcs_rec_type rec;
    logic [TIMER_W-1:0] timer;
    logic [4:0] count;
    logic [HIST_WORDS-1:0][15:0] hist;
    mcs_resp_type resp;
    mcs_ctl_type ctl;
  } mcs_state_type;

endpackage : mcs_pkg

// ==== tb/mcs_cmd_bank_monitor.sv ====
// Port checker for the mfr command bank
`timescale 1ns/100ps
module mcs_monitor
  import mcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire mcs_cmd_type cmd,
  input wire logic [15:0] vin_offset_on,
  input wire logic [15:0] vin_offset_off,
  input wire logic [15:0] vout_trim,
  input wire mcs_resp_type resp,
  input wire mcs_ctl_type ctl,
  input wire logic rec_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  // Command taken at this edge
  assign tk = ce && cmd.valid;
  a_resp_one_later: assert property (tk |=> resp.valid)
    else $error("no answer after command");
  a_offset_block: assert property (tk && cmd.code == CMD_VIN_OFFSET |=>
    resp.data[31:0] == {$past(vin_offset_on), $past(vin_offset_off)}) else $error("offsets");
  a_trim_word: assert property (tk && cmd.code == CMD_VOUT_TRIM |=>
    resp.len == LEN_WORD && resp.data[15:0] == $past(vout_trim)) else $error("trim word");
  a_hist_len: assert property (tk && cmd.code == CMD_STATUS_HIST |=>
    resp.len == LEN_BLK32) else $error("history length");
  a_opt_rsvd_zero: assert property (tk && cmd.code == CMD_SPECIAL_OPT |=>
    (resp.data[7:0] & 8'h13) == 8'h00) else $error("reserved bits set");
  a_pec_refused: assert property (tk && cmd.write && !cmd.pec_ok && ctl.pec_required
    |=> !resp.ack) else $error("write without check accepted");
  a_opt_to_ctl: assert property (tk && cmd.write && cmd.pec_ok && cmd.code == CMD_SPECIAL_OPT
    |=> ctl.dbv_enable == $past(cmd.data[2]) && ctl.adaptive_ramp_loop_comp_enable == $past(cmd.data[3]))
    else $error("option controls");
  a_ratio_needs: assert property (ctl.ratio_track |-> ctl.hrr_enable)
    else $error("ratio tracking without enable");
  a_full_sticks: assert property (rec_full |=> rec_full)
    else $error("history full dropped");
endmodule : mcs_monitor
bind mcs_cmd_bank mcs_monitor i_mon (.clk(clk), .rst_b(rst_b), .ce(ce), .cmd(cmd),
  .vin_offset_on(vin_offset_on), .vin_offset_off(vin_offset_off), .vout_trim(vout_trim),
  .resp(resp), .ctl(ctl), .rec_full(rec_full));

// ==== tb/mcs_cmd_bank_tb.sv ====
// Self-checking bench for the mfr command bank
`timescale 1ns/100ps
module mcs_cmd_bank_tb;
  import mcs_pkg::*;
  localparam int IV = 10;
  logic clk = 0, rst_b = 0, ramp_done = 0, vbt = 0, ok, ea;
  logic [15:0] sw = '0, von = '0, voff = '0, vtr = '0, w;
  logic [7:0] tsrc = '0, opt = '0;
  logic [255:0] hist = '0, ed;
  logic [5:0] el;
  logic [31:0] s = 32'h8501;
  mcs_cmd_type cmd;
  mcs_resp_type resp, r;
  mcs_ctl_type ctl;
  logic rec_busy, rec_full;
  int n_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  mcs_cmd_bank #(.INTERVAL_CYC(IV)) i_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .cmd(cmd),
    .ramp_done(ramp_done), .status_word(sw), .vin_offset_on(von), .vin_offset_off(voff),
    .vout_trim(vtr), .vin_below_thr(vbt), .resp(resp), .ctl(ctl), .rec_busy(rec_busy),
    .rec_full(rec_full));
  mcs_host i_host (.clk(clk), .resp(resp), .cmd(cmd));
  // Xorshift source, low half used
  function automatic logic [15:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[15:0];
  endfunction : xs
  task chk(input logic c, input string m);
    n_checks++;
    if (!c)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task close_out();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // Model is updated after the answer so it still sees the old check-byte setting
  task op(input logic [7:0] c, input logic wr, input logic [7:0] dt, input logic p);
    i_host.xfer(c, wr, dt, p, r, ok);
    ea = 1'b1;
    case (c)
      CMD_TEMP_SRC: {el, ed} = {LEN_BYTE, 248'h0, tsrc};
      CMD_VIN_OFFSET: {el, ed} = {LEN_BLK4, 224'h0, von, voff};
      CMD_VOUT_TRIM: {el, ed} = {LEN_WORD, 240'h0, vtr};
      CMD_STATUS_HIST: {el, ed} = {LEN_BLK32, hist};
      CMD_SPECIAL_OPT: {el, ed} = {LEN_BYTE, 248'h0, opt};
      default: {ea, el, ed} = '0;
    endcase
    if (wr && ea)
      ea = (c == CMD_TEMP_SRC || c == CMD_SPECIAL_OPT) && (p || !opt[7]);
    chk(ok === 1'b1, "no answer");
    if (!ok)
      close_out();
    chk(r.ack === ea && r.len === el, "ack or length");
    if (!wr) chk(r.data === ed, "read data");
    if (wr && ea && c == CMD_TEMP_SRC) tsrc = {7'h0, dt[0]};
    if (wr && ea && c == CMD_SPECIAL_OPT) opt = dt & 8'hEC;
    chk(ctl === {tsrc[0], opt[7], opt[6], opt[6] & vbt, opt[5], opt[3], opt[2]}, "ctl");
  endtask : op
  // Random traffic over all codes plus one unmapped, then the recorder run
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    vbt <= 1'b1;
    repeat (80)
    begin
      von <= xs();
      voff <= xs();
      vtr <= xs();
      op(CMD_TEMP_SRC + 8'(xs() % 6), xs() < 16'h6000, 8'(xs()), xs() < 16'hC000);
    end
    ramp_done <= 1'b1;
    for (int j = 0; j <= 16; j++)
    begin
      w = xs();
      sw <= w;
      if (j > 0) hist[16 * j - 16 +: 16] = w;
      if (j == 8) chk(rec_busy === 1'b1 && rec_full === 1'b0, "mid run");
      repeat (IV) @(posedge clk);
    end
    chk(rec_full === 1'b1, "not full");
    op(CMD_STATUS_HIST, 1'b0, 8'h00, 1'b1);
    close_out();
  end
endmodule : mcs_cmd_bank_tb

// ==== tb/mcs_host.sv ====
// Bus host model: one command pulse, then a bounded wait for its answer
`timescale 1ns/100ps
module mcs_host
  import mcs_pkg::*;
(
  input wire logic clk,
  input wire mcs_resp_type resp,
  output mcs_cmd_type cmd
);
  initial cmd = '0;
  // The answer is caught once; later cycles are ignored
  task xfer(input logic [7:0] c, input logic w, input logic [7:0] d, input logic p,
    output mcs_resp_type r, output logic ok);
    ok = 1'b0;
    @(posedge clk) cmd <= '{1'b1, w, c, d, p};
    @(posedge clk) cmd.valid <= 1'b0;
    repeat (3)
    begin
      @(posedge clk);
      if (!ok && resp.valid === 1'b1)
      begin
        r = resp;
        ok = 1'b1;
      end
    end
  endtask : xfer
endmodule : mcs_host
